// *** core/pbms_top.sv ***
// Port zero and one pin control with processor mode and data bus width straps
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

`include "pbms_defs.svh"

module pbms_top
	import pbms_pkg::*;
(
	// Clock, reset and clock enable
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        ce_in,
	// Straps
	input  wire logic        processor_mode_strap_in,
	input  wire logic        bus_width_strap_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output var  logic [31:0] hrdata_out,
	output var  logic        hreadyout_out,
	output var  logic        hresp_out,
	// External data bus from the core side
	input  wire logic        ext_drive_in,
	input  wire logic [15:0] ext_wdata_in,
	output var  logic [15:0] ext_rdata_out,
	// Port zero pins
	input  wire logic [7:0]  port_zero_bits_in,
	output var  pbms_pad_type port_zero_pad_out,
	// Port one pins
	input  wire logic [7:0]  port_one_bits_in,
	output var  pbms_pad_type port_one_pad_out,
	// Analog channel steering and interrupt inputs
	output var  logic [7:0]  adc_ext_chan_out,
	output var  logic [2:0]  interrupt_capable_bits_out,
	// Configuration seen by the rest of the chip
	output var  pbms_mode_type mode_out,
	output var  logic        bus_byte8_out
);

	// ======================================================================
	// Declarations
	logic          strap_done_ff;   // Straps have been caught since reset
	logic          strap_micro_ff;  // Caught processor mode strap
	logic          strap_byte8_ff;  // Caught bus width strap
	logic          ctrl_expand_ff;  // Software asks for memory expansion
	logic [15:0]   dir_ff;          // Direction, port one in upper byte
	logic [15:0]   out_ff;          // Output latches
	logic [3:0]    pull_ff;         // Pull-up groups, two per port
	logic [7:0]    adc_sel_ff;      // Port zero pins given to the converter
	logic [2:0]    irq_sel_ff;      // Port one top pins given to interrupts
	pbms_mode_type nxt_mode;        // Mode from straps and control
	logic          wr_pend_ff;      // Write data phase pending
	logic [7:0]    wr_addr_ff;      // Address of pending write
	logic          addr_ok;         // Valid address phase this cycle
	logic [31:0]   nxt_rdata;       // Read mux
	logic [7:0]    p0_val;          // Sampled port zero pins
	logic [7:0]    p1_val;          // Sampled port one pins
	logic          single;          // Single-chip mode active
	logic          bus_lo;          // Port zero carries data
	logic          bus_hi;          // Port one carries data
	pbms_port_ctl_type p0_ctl;      // Port zero control bundle
	pbms_port_ctl_type p1_ctl;      // Port one control bundle

	// ======================================================================
	// Strap capture
	// The straps are caught on the first enabled edge after release, never
	// under the reset itself, so the asynchronous reset loads only constants.
	// Until then the block stays in single-chip mode with all pins as inputs.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			strap_done_ff  <= 1'b0;
			strap_micro_ff <= 1'b0;
			strap_byte8_ff <= 1'b0;
		end else if (ce_in && !strap_done_ff) begin
			strap_done_ff  <= 1'b1;
			strap_micro_ff <= processor_mode_strap_in;
			strap_byte8_ff <= bus_width_strap_in;
		end
	end

	// ======================================================================
	// Mode decision
	// Microprocessor mode wins over the software expansion request; the
	// request only matters while the strap was low.
	always_comb begin
		if (!strap_done_ff) begin
			nxt_mode = PBMS_MODE_SINGLE;
		end else if (strap_micro_ff) begin
			nxt_mode = PBMS_MODE_MICRO;
		end else if (ctrl_expand_ff) begin
			nxt_mode = PBMS_MODE_EXPAND;
		end else begin
			nxt_mode = PBMS_MODE_SINGLE;
		end
	end

	// Mode and width outputs
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode_out      <= PBMS_MODE_SINGLE;
			bus_byte8_out <= 1'b0;
		end else if (ce_in) begin
			mode_out      <= nxt_mode;
			bus_byte8_out <= strap_byte8_ff;
		end
	end

	// Decoded views of the registered mode
	assign single = (mode_out == PBMS_MODE_SINGLE);
	assign bus_lo = !single;
	assign bus_hi = !single && !bus_byte8_out;

	// ======================================================================
	// AHB-Lite address phase
	// Zero wait states: hreadyout stays high, so every phase is taken at once.
	assign addr_ok = hsel_in && hready_in && htrans_in[1];

	// Latch write address for the data phase
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else if (ce_in) begin
			wr_pend_ff <= addr_ok && hwrite_in;
			wr_addr_ff <= haddr_in[7:0];
		end
	end

	// ======================================================================
	// Read mux, unmapped offsets read as zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (haddr_in[31:8] != 24'h00_0000) begin
			nxt_rdata = 32'h0000_0000;
		end else if (haddr_in[7:0] == `PBMS_OFS_CTRL) begin
			nxt_rdata[`PBMS_CTRL_EXPAND_BIT] = ctrl_expand_ff;
		end else if (haddr_in[7:0] == `PBMS_OFS_DIR) begin
			nxt_rdata[15:0] = dir_ff;
		end else if (haddr_in[7:0] == `PBMS_OFS_OUT) begin
			nxt_rdata[15:0] = out_ff;
		end else if (haddr_in[7:0] == `PBMS_OFS_PULL) begin
			nxt_rdata[3:0] = pull_ff;
		end else if (haddr_in[7:0] == `PBMS_OFS_ADC_SEL) begin
			nxt_rdata[7:0] = adc_sel_ff;
		end else if (haddr_in[7:0] == `PBMS_OFS_IRQ_SEL) begin
			nxt_rdata[2:0] = irq_sel_ff;
		end else if (haddr_in[7:0] == `PBMS_OFS_PIN_IN) begin
			nxt_rdata[15:0] = {p1_val, p0_val};
		end else if (haddr_in[7:0] == `PBMS_OFS_STATUS) begin
			nxt_rdata[`PBMS_STAT_MICRO_BIT]  = strap_micro_ff;
			nxt_rdata[`PBMS_STAT_BYTE8_BIT]  = strap_byte8_ff;
			nxt_rdata[`PBMS_STAT_EXPAND_BIT] = (mode_out == PBMS_MODE_EXPAND);
			nxt_rdata[`PBMS_STAT_DONE_BIT]   = strap_done_ff;
		end
	end

	// Read data and response, registered so they stand in the data phase
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hrdata_out    <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else if (ce_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			if (addr_ok && !hwrite_in) begin
				hrdata_out <= nxt_rdata;
			end else begin
				hrdata_out <= 32'h0000_0000;
			end
		end
	end

	// ======================================================================
	// Register writes in the data phase
	// hsize is not checked: only whole-word transfers are expected.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_expand_ff <= `PBMS_RST_CTRL;
			dir_ff         <= `PBMS_RST_DIR;
			out_ff         <= `PBMS_RST_OUT;
			pull_ff        <= `PBMS_RST_PULL;
			adc_sel_ff     <= `PBMS_RST_ADC_SEL;
			irq_sel_ff     <= `PBMS_RST_IRQ_SEL;
		end else if (ce_in && wr_pend_ff) begin
			if (wr_addr_ff == `PBMS_OFS_CTRL) begin
				ctrl_expand_ff <= hwdata_in[`PBMS_CTRL_EXPAND_BIT];
			end else if (wr_addr_ff == `PBMS_OFS_DIR) begin
				dir_ff <= hwdata_in[15:0];
			end else if (wr_addr_ff == `PBMS_OFS_OUT) begin
				out_ff <= hwdata_in[15:0];
			end else if (wr_addr_ff == `PBMS_OFS_PULL) begin
				pull_ff <= hwdata_in[3:0];
			end else if (wr_addr_ff == `PBMS_OFS_ADC_SEL) begin
				adc_sel_ff <= hwdata_in[7:0];
			end else if (wr_addr_ff == `PBMS_OFS_IRQ_SEL) begin
				irq_sel_ff <= hwdata_in[2:0];
			end
		end
	end

	// ======================================================================
	// Port control bundles
	// Analog and interrupt use force the pin to input so nothing fights the
	// external source; the direction latch itself is left as written.
	always_comb begin
		p0_ctl           = '0;
		p0_ctl.dir       = dir_ff[7:0];
		p0_ctl.out       = out_ff[7:0];
		p0_ctl.pull_nib  = pull_ff[1:0];
		p0_ctl.hold_in   = single ? adc_sel_ff : 8'h00;
		p0_ctl.single    = single;
		p0_ctl.bus       = bus_lo;
		p0_ctl.bus_drive = ext_drive_in;
		p0_ctl.bus_data  = ext_wdata_in[7:0];
	end

	// Port one mirrors port zero, interrupt pins instead of analog pins
	always_comb begin
		p1_ctl           = '0;
		p1_ctl.dir       = dir_ff[15:8];
		p1_ctl.out       = out_ff[15:8];
		p1_ctl.pull_nib  = pull_ff[3:2];
		p1_ctl.hold_in   = {irq_sel_ff, 5'h00};
		p1_ctl.single    = single;
		p1_ctl.bus       = bus_hi;
		p1_ctl.bus_drive = ext_drive_in;
		p1_ctl.bus_data  = ext_wdata_in[15:8];
	end

	// ======================================================================
	// Port instances
	pbms_port_cell u_port_zero (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.ce_in       (ce_in),
		.ctl_in      (p0_ctl),
		.pin_in      (port_zero_bits_in),
		.pad_out     (port_zero_pad_out),
		.pin_val_out (p0_val)
	);

	pbms_port_cell u_port_one (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.ce_in       (ce_in),
		.ctl_in      (p1_ctl),
		.pin_in      (port_one_bits_in),
		.pad_out     (port_one_pad_out),
		.pin_val_out (p1_val)
	);

	// ======================================================================
	// Side functions: analog steering, interrupt inputs, bus read data
	// In 8-bit width the high byte reads as zero; the core must not use it.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			adc_ext_chan_out           <= 8'h00;
			interrupt_capable_bits_out <= 3'h0;
			ext_rdata_out              <= 16'h0000;
		end else if (ce_in) begin
			adc_ext_chan_out <= single ? adc_sel_ff : 8'h00;
			if (!bus_hi) begin
				interrupt_capable_bits_out <= irq_sel_ff
					& p1_val[`PBMS_IRQ_LSB +: 3];
			end else begin
				interrupt_capable_bits_out <= 3'h0;
			end
			ext_rdata_out[7:0]  <= bus_lo ? p0_val : 8'h00;
			ext_rdata_out[15:8] <= bus_hi ? p1_val : 8'h00;
		end
	end

endmodule : pbms_top

`default_nettype wire

// *** shared/pbms_defs.svh ***
// Constants of the port, bus and pin-mode select block: offsets, fields, reset values
`ifndef PBMS_DEFS_SVH
`define PBMS_DEFS_SVH

// ==========================================================================
// Register byte offsets on the register bus
`define PBMS_OFS_CTRL     8'h00
`define PBMS_OFS_DIR      8'h04
`define PBMS_OFS_OUT      8'h08
`define PBMS_OFS_PULL     8'h0c
`define PBMS_OFS_ADC_SEL  8'h10
`define PBMS_OFS_IRQ_SEL  8'h14
`define PBMS_OFS_PIN_IN   8'h18
`define PBMS_OFS_STATUS   8'h1c

// ==========================================================================
// Field positions
`define PBMS_CTRL_EXPAND_BIT   0
`define PBMS_STAT_MICRO_BIT    0
`define PBMS_STAT_BYTE8_BIT    1
`define PBMS_STAT_EXPAND_BIT   2
`define PBMS_STAT_DONE_BIT     3
`define PBMS_IRQ_LSB           5

// ==========================================================================
// Reset values
`define PBMS_RST_CTRL     1'h0
`define PBMS_RST_DIR      16'h0000
`define PBMS_RST_OUT      16'h0000
`define PBMS_RST_PULL     4'h0
`define PBMS_RST_ADC_SEL  8'h00
`define PBMS_RST_IRQ_SEL  3'h0

`endif

// *** shared/pbms_pkg.sv ***
// Types shared by the port, bus and pin-mode select block
package pbms_pkg;

	// ======================================================================
	// Processor mode, Gray coded along single -> expansion -> microprocessor
	typedef enum logic [1:0] {
		PBMS_MODE_SINGLE = 2'h0,
		PBMS_MODE_EXPAND = 2'h1,
		PBMS_MODE_MICRO  = 2'h3
	} pbms_mode_type;

	// ======================================================================
	// Control bundle for one eight-bit port
	typedef struct packed {
		logic [7:0] dir;       // 1 = output per pin
		logic [7:0] out;       // Output latch
		logic [1:0] pull_nib;  // Pull-up request per group of four
		logic [7:0] hold_in;   // Pins forced to input (analog or interrupt use)
		logic       single;    // Single-chip mode: pull-ups allowed
		logic       bus;       // Port carries an external data byte
		logic       bus_drive; // Device drives the data byte
		logic [7:0] bus_data;  // Data byte to drive
	} pbms_port_ctl_type;

	// ======================================================================
	// Pad side of one eight-bit port
	typedef struct packed {
		logic [7:0] out;  // Level driven
		logic [7:0] oe;   // High while the device drives the pin
		logic [7:0] pull; // Internal pull-up enabled
	} pbms_pad_type;

endpackage : pbms_pkg

// *** core/pbms_port_cell.sv ***
// One eight-bit port: direction, pull-up groups and external data byte steering
`timescale 1ns/10ps
`default_nettype none

module pbms_port_cell
	import pbms_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              resetn_in,
	input  wire logic              ce_in,
	// Control
	input  wire pbms_port_ctl_type ctl_in,
	// Pins
	input  wire logic [7:0]        pin_in,
	output var  pbms_pad_type      pad_out,
	output var  logic [7:0]        pin_val_out
);

	// ======================================================================
	// Per-pin steering, every pad signal registered
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			// Output drive, enable and pull-up of one pin
			always_ff @(posedge core_clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					pad_out.out[gi]  <= 1'b0;
					pad_out.oe[gi]   <= 1'b0;
					pad_out.pull[gi] <= 1'b0;
					pin_val_out[gi]  <= 1'b0;
				end else if (ce_in) begin
					pin_val_out[gi] <= pin_in[gi];
					if (ctl_in.bus) begin
						// Data byte: direction follows the bus cycle, no pull-up
						pad_out.out[gi]  <= ctl_in.bus_data[gi];
						pad_out.oe[gi]   <= ctl_in.bus_drive;
						pad_out.pull[gi] <= 1'b0;
					end else begin
						// General I/O, each pin its own direction
						pad_out.out[gi]  <= ctl_in.out[gi];
						pad_out.oe[gi]   <= ctl_in.dir[gi] & ~ctl_in.hold_in[gi];
						// Pull-up only on inputs, per nibble, single-chip only
						pad_out.pull[gi] <= ctl_in.single & ~ctl_in.dir[gi]
							& ctl_in.pull_nib[gi/4];
					end
				end
			end
		end
	endgenerate

endmodule : pbms_port_cell

`default_nettype wire

// *** dv/pbms_monitor.sv ***
// Concurrent checks on the ports of the pin-mode select top
`timescale 1ns/10ps
`default_nettype none

module pbms_monitor
	import pbms_pkg::*;
(
	// Clock, reset and straps
	input wire logic          core_clk_in,
	input wire logic          resetn_in,
	input wire logic          processor_mode_strap_in,
	input wire logic          bus_width_strap_in,
	// Core side of the data bus
	input wire logic          ext_drive_in,
	input wire logic [15:0]   ext_wdata_in,
	// Pads and configuration
	input wire pbms_pad_type  port_zero_pad_out,
	input wire pbms_pad_type  port_one_pad_out,
	input wire logic [7:0]    adc_ext_chan_out,
	input wire pbms_mode_type mode_out,
	input wire logic          bus_byte8_out
);
	// ======================================================================
	// Helpers: edges since release, caught straps, bus mode history
	logic [1:0] cnt_ff;
	logic       micro_ff, byte8_ff, ns1_ff, ns2_ff;
	logic       ns, b2;
	assign ns = mode_out != PBMS_MODE_SINGLE;
	// Pads lag the mode by an edge, so bus checks wait two steady cycles
	assign b2 = ns && ns1_ff && ns2_ff;
	// Saturating count so later strap wiggles are never resampled
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_ff <= 2'h0;
			ns1_ff <= 1'b0;
			ns2_ff <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == 2'h3) ? cnt_ff : cnt_ff + 2'h1;
			ns1_ff <= ns;
			ns2_ff <= ns1_ff;
		end
	end
	// Straps as seen at the first edge after release
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			micro_ff <= 1'b0;
			byte8_ff <= 1'b0;
		end else if (cnt_ff == 2'h0) begin
			micro_ff <= processor_mode_strap_in;
			byte8_ff <= bus_width_strap_in;
		end
	end
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!resetn_in);

	// ======================================================================
	// Properties
	property p_rst;
		cnt_ff == 2'h0 |-> !ns && (port_zero_pad_out.oe | port_one_pad_out.oe) == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_mode;
		cnt_ff == 2'h3 |-> (mode_out == PBMS_MODE_MICRO) == micro_ff;
	endproperty
	a_mode: assert property (p_mode) else $error("mode differs from strap");
	property p_width;
		cnt_ff == 2'h3 |-> bus_byte8_out == byte8_ff;
	endproperty
	a_width: assert property (p_width) else $error("width differs from strap");
	property p_nopull;
		b2 |-> (port_zero_pad_out.pull | port_one_pad_out.pull) == 8'h00;
	endproperty
	a_nopull: assert property (p_nopull) else $error("pull-up in bus mode");
	property p_pullin;
		((port_zero_pad_out.pull & port_zero_pad_out.oe) | (port_one_pad_out.pull
			& port_one_pad_out.oe)) == 8'h00;
	endproperty
	a_pullin: assert property (p_pullin) else $error("pull-up on driven pin");
	property p_low;
		b2 |-> port_zero_pad_out.oe == {8{$past(ext_drive_in)}} && (!$past(ext_drive_in)
			|| port_zero_pad_out.out == $past(ext_wdata_in[7:0]));
	endproperty
	a_low: assert property (p_low) else $error("low byte not on port zero");
	property p_high;
		b2 && !bus_byte8_out && $past(ext_drive_in) |-> port_one_pad_out.oe == 8'hff
			&& port_one_pad_out.out == $past(ext_wdata_in[15:8]);
	endproperty
	a_high: assert property (p_high) else $error("high byte not on port one");
	property p_adc;
		b2 |-> adc_ext_chan_out == 8'h00;
	endproperty
	a_adc: assert property (p_adc) else $error("analog input in bus mode");
endmodule : pbms_monitor

bind pbms_top pbms_monitor pbms_monitor_i (.core_clk_in, .resetn_in,
	.processor_mode_strap_in, .bus_width_strap_in, .ext_drive_in, .ext_wdata_in,
	.port_zero_pad_out, .port_one_pad_out, .adc_ext_chan_out, .mode_out, .bus_byte8_out);

`default_nettype wire

// *** dv/pbms_board.sv ***
// Board model: strap wiring and external memory on the port pins
`timescale 1ns/10ps
`default_nettype none

module pbms_board
	import pbms_pkg::*;
(
	// Clock and device pads
	input  wire logic         core_clk_in,
	input  wire pbms_pad_type zero_pad_in,
	input  wire pbms_pad_type one_pad_in,
	// Memory drive and strap choices
	input  wire logic         mem_drive_in,
	input  wire logic [15:0]  mem_data_in,
	input  wire logic         mode_sel_in,
	input  wire logic         width_sel_in,
	// Pin levels and straps
	output var  logic [15:0]  pins_out,
	output var  logic         mode_strap_out,
	output var  logic         width_strap_out
);
	// ======================================================================
	// Released pins with nobody driving show high if pulled up, else the inverse of the last level
	logic [15:0] last_ff, oe, val, pul;
	assign oe  = {one_pad_in.oe, zero_pad_in.oe};
	assign val = {one_pad_in.out, zero_pad_in.out};
	assign pul = {one_pad_in.pull, zero_pad_in.pull};
	// Memory only drives pins that the device has let go
	assign pins_out = (oe & val) | (~oe & (mem_drive_in ? mem_data_in : pul | ~last_ff));
	// Last level, for the floating pattern
	always_ff @(posedge core_clk_in) begin
		last_ff <= pins_out;
	end
	// Fixed wiring; both straps pass straight through from the selection inputs
	assign mode_strap_out  = mode_sel_in;
	assign width_strap_out = width_sel_in;
endmodule : pbms_board

`default_nettype wire

// *** dv/pbms_top_tb.sv ***
// Self-checking bench for the pin-mode select top with a board model
`timescale 1ns/10ps
`default_nettype none
`include "pbms_defs.svh"

module pbms_top_tb;
	import pbms_pkg::*;
	// ======================================================================
	// Signals and model state
	logic          clk, resetn, hsel, hwrite, hready, hresp, ext_drive, mem_drive, b8;
	logic          mode_sel, width_sel, mode_strap, width_strap, m_single, m_b8;
	logic [1:0]    htrans;
	logic [2:0]    hsize, irq, m_irq;
	logic [3:0]    m_pull;
	logic [7:0]    adc, m_adc;
	logic [15:0]   ext_wdata, ext_rdata, mem_data, pins, m_dir, m_out;
	logic [31:0]   haddr, hwdata, hrdata, seed, rd;
	pbms_pad_type  pad0, pad1;
	pbms_mode_type mode;
	int            n_mismatch, tests_run;

	pbms_top pbms_top_i (.core_clk_in(clk), .resetn_in(resetn), .ce_in(1'b1),
		.processor_mode_strap_in(mode_strap), .bus_width_strap_in(width_strap),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .ext_drive_in(ext_drive),
		.ext_wdata_in(ext_wdata), .ext_rdata_out(ext_rdata), .port_zero_bits_in(pins[7:0]),
		.port_zero_pad_out(pad0), .port_one_bits_in(pins[15:8]), .port_one_pad_out(pad1),
		.adc_ext_chan_out(adc), .interrupt_capable_bits_out(irq), .mode_out(mode),
		.bus_byte8_out(b8));
	pbms_board pbms_board_i (.core_clk_in(clk), .zero_pad_in(pad0), .one_pad_in(pad1),
		.mem_drive_in(mem_drive), .mem_data_in(mem_data), .mode_sel_in(mode_sel),
		.width_sel_in(width_sel), .pins_out(pins), .mode_strap_out(mode_strap),
		.width_strap_out(width_strap));

	// ======================================================================
	// Reference model
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Expected {driven out, oe, pull} of port p
	function automatic logic [23:0] exp_pad(input int p);
		logic       bp;
		logic [7:0] d, o, h, pu, oe;
		bp = !m_single && (p == 0 || !m_b8);
		d  = m_dir[p*8 +: 8];
		h  = (p == 0) ? (m_single ? m_adc : 8'h00) : {m_irq, 5'h00};
		oe = bp ? {8{ext_drive}} : d & ~h;
		o  = bp ? ext_wdata[p*8 +: 8] : m_out[p*8 +: 8];
		pu = (m_single ? {{4{m_pull[p*2+1]}}, {4{m_pull[p*2]}}} : 8'h00) & ~d;
		return {o & oe, oe, pu};
	endfunction : exp_pad
	// Pin levels: device where driving, memory elsewhere
	function automatic logic [15:0] exp_pins();
		logic [23:0] a, b;
		a = exp_pad(0);
		b = exp_pad(1);
		return {b[23:16] | ~b[15:8] & mem_data[15:8], a[23:16] | ~a[15:8] & mem_data[7:0]};
	endfunction : exp_pins

	// ======================================================================
	// Checking, bus and sequence tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	// Bounded wait for hready at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		// Judge by the ready level itself, so a ready seen on the last try still counts
		if (hready !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: bus hang", $time);
			stop_test();
		end
		// The slave must answer OKAY on every phase
		if (hresp !== 1'b0) begin
			n_mismatch++;
			$display("unexpected at %0t: bus error response", $time);
		end
	endtask : wait_rdy
	// One single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	// Reset with the given straps, model back to reset values
	task automatic start(input logic m, input logic w);
		resetn    <= 1'b0;
		mode_sel  <= m;
		width_sel <= w;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		{m_dir, m_out, m_adc, m_pull, m_irq} = '0;
		m_single = !m;
		m_b8     = w;
	endtask : start
	task automatic pads();
		repeat (3) @(posedge clk);
		chk({pad0.out & pad0.oe, pad0.oe, pad0.pull}, exp_pad(0));
		chk({pad1.out & pad1.oe, pad1.oe, pad1.pull}, exp_pad(1));
	endtask : pads
	// Random bus traffic; memory drives only while the device does not
	task automatic drv_loop(input int n);
		logic [15:0] p;
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			ext_drive <= seed[0];
			mem_drive <= !seed[0];
			ext_wdata <= seed[16:1];
			mem_data  <= seed[31:16];
			pads();
			repeat (3) @(posedge clk);
			p = exp_pins();
			chk(ext_rdata, {(m_single || m_b8) ? 8'h00 : p[15:8], p[7:0]});
			chk(irq, 3'h0);
		end
	endtask : drv_loop

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{resetn, hwrite, ext_drive, mode_sel, width_sel, htrans} = '0;
		{hsel, mem_drive, hsize} = 5'h1a;
		{haddr, hwdata, rd, ext_wdata, mem_data} = '0;
		n_mismatch = 0;
		tests_run  = 0;
		seed       = 32'h9a93;
		@(posedge clk);
		// Single-chip, 16-bit: reset values, unmapped place
		start(1'b0, 1'b0);
		for (int a = 0; a < 6; a++) begin
			rdc(8'(a * 4), 32'h0);
		end
		rdc(`PBMS_OFS_STATUS, 32'h8);
		bus(1'b1, 8'h20, 32'hffffffff);
		rdc(8'h20, 32'h0);
		// Random direction, pull groups, analog and interrupt use
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			{m_out, m_dir} = seed;
			seed = lfsr(seed);
			{m_adc, m_pull, m_irq} = seed[14:0];
			mem_data <= seed[31:16];
			bus(1'b1, `PBMS_OFS_DIR, {16'h0, m_dir});
			bus(1'b1, `PBMS_OFS_OUT, {16'h0, m_out});
			bus(1'b1, `PBMS_OFS_PULL, {28'h0, m_pull});
			bus(1'b1, `PBMS_OFS_ADC_SEL, {24'h0, m_adc});
			bus(1'b1, `PBMS_OFS_IRQ_SEL, {29'h0, m_irq});
			pads();
			chk(adc, m_adc);
			rdc(`PBMS_OFS_PULL, {28'h0, m_pull});
			rd = {16'h0, exp_pins()};
			chk(irq, rd[15:13] & m_irq);
			rdc(`PBMS_OFS_PIN_IN, rd);
		end
		// Expansion by software: pulls and analog use drop away
		bus(1'b1, `PBMS_OFS_CTRL, 32'h1);
		m_single = 1'b0;
		repeat (3) @(posedge clk);
		chk(mode, PBMS_MODE_EXPAND);
		rdc(`PBMS_OFS_STATUS, 32'hc);
		drv_loop(6);
		chk(adc, 8'h00);
		// Microprocessor mode, 8-bit; straps then moved on purpose
		start(1'b1, 1'b1);
		chk({b8, mode}, {1'b1, PBMS_MODE_MICRO});
		drv_loop(4);
		mode_sel  <= 1'b0;
		width_sel <= 1'b0;
		repeat (4) @(posedge clk);
		chk({b8, mode}, {1'b1, PBMS_MODE_MICRO});
		rdc(`PBMS_OFS_STATUS, 32'hb);
		// Microprocessor mode, 16-bit
		start(1'b1, 1'b0);
		chk(b8, 1'b0);
		drv_loop(4);
		stop_test();
	end
endmodule : pbms_top_tb

`default_nettype wire
